// [hw/octal_entry_pkg.sv]
package octal_entry_pkg;
    // Register byte offsets
    localparam logic [7:0] SEQ_WORD_BASE   = 8'h00;
    localparam logic [7:0] QUAD_LEN_OFS    = 8'h20;
    localparam logic [7:0] QUAD_PTR_OFS    = 8'h24;
    localparam logic [7:0] OCTAL_PTR_OFS   = 8'h28;
    localparam logic [7:0] STATUS_OFS      = 8'h2C;
    localparam int         SEQ_WORDS       = 8;
    localparam int         SEQ_COUNT       = 4;
    localparam int         SEQ_MAX_BYTES   = 7;
    // Header fields
    localparam logic [7:0] OCTAL_IDENT_LOW = 8'h0A;
    localparam logic [7:0] QUAD_IDENT_LOW  = 8'h0C;
    localparam logic [7:0] IDENT_HIGH      = 8'hFF;
    localparam logic [7:0] MAJOR_REV       = 8'h01;
    localparam logic [7:0] MINOR_REV       = 8'h00;
    localparam logic [7:0] OCTAL_TABLE_LEN = 8'h08;
    // Reset values
    localparam logic [7:0]  QUAD_LEN_RST   = 8'h05;
    localparam logic [23:0] QUAD_PTR_RST   = 24'h000100;
    localparam logic [23:0] OCTAL_PTR_RST  = 24'h000080;
    // Link word index map
    localparam logic [7:0] IDX_OCTAL_HDR0  = 8'h00;
    localparam logic [7:0] IDX_OCTAL_HDR1  = 8'h01;
    localparam logic [7:0] IDX_QUAD_HDR0   = 8'h02;
    localparam logic [7:0] IDX_QUAD_HDR1   = 8'h03;
    localparam logic [7:0] IDX_SEQ_BASE    = 8'h04;
    localparam logic [5:0] INDEX_BITS      = 6'h08;
    localparam logic [5:0] FRAME_BITS      = 6'h28;
endpackage : octal_entry_pkg

// [hw/octal_ddr_entry_sequence_parser.sv]
`timescale 1ns/1ps
// Behaviour
// - Top byte of a sequence's first word is its length; zero means absent.
// - First word carries bytes one to three, high byte first.
// - Second word carries bytes four to seven; bytes past length are unused.
// - Sequences two to four use word pairs three-four, five-six, seven-eight.
// - Quad header top byte gives table length in words, one-based.
// - Quad header bits 23:16 hold major revision 01h.
// - Quad header bits 15:8 hold minor revision 00h.
// - Quad header first word low byte is identifier low byte 0Ch.
// - Second header word top byte is identifier high byte FFh.
// - Second header word low 24 bits give word-aligned table start address.
// - Octal entry table is identified by low identifier byte 0Ah.
module octal_ddr_entry_sequence_parser
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst_n,
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic        i_link_clk,
    input  wire logic        i_link_sel_n,
    input  wire logic        i_link_mosi,
    output logic             o_link_miso
);

    // ------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------
    logic rst_meta_q;
    logic rst_sync_n_q;

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rst_meta_q   <= 1'b0;
            rst_sync_n_q <= 1'b0;
        end
        else
        begin
            rst_meta_q   <= 1'b1;
            rst_sync_n_q <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [31:0] seq_word_q [octal_entry_pkg::SEQ_WORDS];
    logic [7:0]  quad_len_q;
    logic [23:0] quad_ptr_q;
    logic [23:0] octal_ptr_q;
    logic        link_active_q;
    logic [7:0]  last_index_q;
    logic [31:0] quad_ptr_merged;
    logic [31:0] octal_ptr_merged;
    logic [31:0] word_now;
    logic [31:0] word_next;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
            begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge_bytes

    // Sequence byte k (1..7) sits in word pair; bytes past length read zero
    function automatic logic [31:0] seq_view(input logic [31:0] first_w,
                                             input logic [31:0] second_w,
                                             input logic        second);
        logic [7:0]  len;
        logic [31:0] r;
        logic [3:0]  k;
        len = first_w[31:24];
        r   = 32'h00000000;
        for (int b = 0; b < 4; b++)
        begin
            k = second ? 4'(4 + 3 - b) : 4'(3 - b);
            if (k != 4'h0 && k <= 4'(octal_entry_pkg::SEQ_MAX_BYTES)
                && {4'h0, k} <= len)
            begin
                r[b*8 +: 8] = second ? second_w[b*8 +: 8] : first_w[b*8 +: 8];
            end
        end
        if (!second)
        begin
            r[31:24] = len;
        end
        return r;
    endfunction : seq_view

    function automatic logic [31:0] table_word(input logic [7:0] idx);
        logic [31:0] r;
        logic [7:0]  s;
        r = 32'h00000000;
        s = idx - octal_entry_pkg::IDX_SEQ_BASE;
        unique case (idx)
            octal_entry_pkg::IDX_OCTAL_HDR0:
                r = {octal_entry_pkg::OCTAL_TABLE_LEN, octal_entry_pkg::MAJOR_REV,
                     octal_entry_pkg::MINOR_REV, octal_entry_pkg::OCTAL_IDENT_LOW};
            octal_entry_pkg::IDX_OCTAL_HDR1:
                r = {octal_entry_pkg::IDENT_HIGH, octal_ptr_q};
            octal_entry_pkg::IDX_QUAD_HDR0:
                r = {quad_len_q, octal_entry_pkg::MAJOR_REV,
                     octal_entry_pkg::MINOR_REV, octal_entry_pkg::QUAD_IDENT_LOW};
            octal_entry_pkg::IDX_QUAD_HDR1:
                r = {octal_entry_pkg::IDENT_HIGH, quad_ptr_q};
            default:
            begin
                if (s < 8'(octal_entry_pkg::SEQ_WORDS))
                begin
                    // Pairs (1,2) (3,4) (5,6) (7,8)
                    r = seq_view(seq_word_q[{s[2:1], 1'b0}],
                                 seq_word_q[{s[2:1], 1'b1}], s[0]);
                end
            end
        endcase
        return r;
    endfunction : table_word

    // ------------------------------------------------------------
    // Avalon-MM slave
    // ------------------------------------------------------------
    logic        wait_q;
    logic [31:0] rdata_q;
    logic        bus_req;
    logic        bus_write_now;
    logic [2:0]  nonempty;

    assign bus_req       = i_avs_read | i_avs_write;
    assign bus_write_now = i_avs_write & ~wait_q;

    always_comb
    begin
        quad_ptr_merged  = merge_bytes({8'h00, quad_ptr_q}, i_avs_writedata, i_avs_byteenable);
        octal_ptr_merged = merge_bytes({8'h00, octal_ptr_q}, i_avs_writedata, i_avs_byteenable);
        word_now         = table_word(index_q);
        word_next        = table_word(index_q + 8'h01);
        nonempty = 3'h0;
        for (int q = 0; q < octal_entry_pkg::SEQ_COUNT; q++)
        begin
            if (seq_word_q[2*q][31:24] != 8'h00)
            begin
                nonempty = nonempty + 3'h1;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_sync_n_q)
    begin
        if (!rst_sync_n_q)
        begin
            wait_q <= 1'b1;
        end
        else
        begin
            wait_q <= ~(bus_req & wait_q);
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_sync_n_q)
    begin
        if (!rst_sync_n_q)
        begin
            rdata_q <= 32'h00000000;
        end
        else if (i_avs_read && wait_q)
        begin
            if (i_avs_address < octal_entry_pkg::QUAD_LEN_OFS
                && i_avs_address[1:0] == 2'h0)
            begin
                rdata_q <= seq_word_q[i_avs_address[4:2]];
            end
            else
            begin
                unique case (i_avs_address)
                    octal_entry_pkg::QUAD_LEN_OFS:  rdata_q <= {24'h000000, quad_len_q};
                    octal_entry_pkg::QUAD_PTR_OFS:  rdata_q <= {8'h00, quad_ptr_q};
                    octal_entry_pkg::OCTAL_PTR_OFS: rdata_q <= {8'h00, octal_ptr_q};
                    octal_entry_pkg::STATUS_OFS:
                        rdata_q <= {19'h00000, last_index_q, 1'b0, nonempty, link_active_q};
                    default:                        rdata_q <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_sync_n_q)
    begin
        if (!rst_sync_n_q)
        begin
            for (int w = 0; w < octal_entry_pkg::SEQ_WORDS; w++)
            begin
                seq_word_q[w] <= 32'h00000000;
            end
            quad_len_q  <= octal_entry_pkg::QUAD_LEN_RST;
            quad_ptr_q  <= octal_entry_pkg::QUAD_PTR_RST;
            octal_ptr_q <= octal_entry_pkg::OCTAL_PTR_RST;
        end
        else if (bus_write_now)
        begin
            if (i_avs_address < octal_entry_pkg::QUAD_LEN_OFS
                && i_avs_address[1:0] == 2'h0)
            begin
                seq_word_q[i_avs_address[4:2]] <= merge_bytes(seq_word_q[i_avs_address[4:2]],
                                                              i_avs_writedata, i_avs_byteenable);
            end
            else if (i_avs_address == octal_entry_pkg::QUAD_LEN_OFS && i_avs_byteenable[0])
            begin
                // One-based: zero is not a legal length
                quad_len_q <= (i_avs_writedata[7:0] == 8'h00) ? 8'h01
                                                             : i_avs_writedata[7:0];
            end
            else if (i_avs_address == octal_entry_pkg::QUAD_PTR_OFS)
            begin
                quad_ptr_q <= {quad_ptr_merged[23:2], 2'b00};
            end
            else if (i_avs_address == octal_entry_pkg::OCTAL_PTR_OFS)
            begin
                octal_ptr_q <= {octal_ptr_merged[23:2], 2'b00};
            end
        end
    end

    assign o_avs_readdata    = rdata_q;
    assign o_avs_waitrequest = wait_q;

    // ------------------------------------------------------------
    // Link sampling
    // ------------------------------------------------------------
    logic [2:0] clk_sync_q;
    logic [1:0] sel_sync_q;
    logic [1:0] mosi_sync_q;
    logic       link_rise;
    logic       link_fall;

    always_ff @(posedge i_sys_clk or negedge rst_sync_n_q)
    begin
        if (!rst_sync_n_q)
        begin
            clk_sync_q  <= 3'h0;
            sel_sync_q  <= 2'h3;
            mosi_sync_q <= 2'h0;
        end
        else
        begin
            clk_sync_q  <= {clk_sync_q[1:0], i_link_clk};
            sel_sync_q  <= {sel_sync_q[0], i_link_sel_n};
            mosi_sync_q <= {mosi_sync_q[0], i_link_mosi};
        end
    end

    assign link_rise = clk_sync_q[1] & ~clk_sync_q[2];
    assign link_fall = ~clk_sync_q[1] & clk_sync_q[2];

    // ------------------------------------------------------------
    // Link word server
    // ------------------------------------------------------------
    logic [5:0]  bit_cnt_q;
    logic [7:0]  index_q;
    logic [31:0] shift_q;
    logic        miso_q;

    always_ff @(posedge i_sys_clk or negedge rst_sync_n_q)
    begin
        if (!rst_sync_n_q)
        begin
            bit_cnt_q     <= 6'h00;
            index_q       <= 8'h00;
            shift_q       <= 32'h00000000;
            miso_q        <= 1'b0;
            link_active_q <= 1'b0;
            last_index_q  <= 8'h00;
        end
        else if (sel_sync_q[1])
        begin
            bit_cnt_q     <= 6'h00;
            link_active_q <= 1'b0;
            miso_q        <= 1'b0;
        end
        else
        begin
            link_active_q <= 1'b1;
            if (link_rise && bit_cnt_q < octal_entry_pkg::INDEX_BITS)
            begin
                index_q   <= {index_q[6:0], mosi_sync_q[1]};
                bit_cnt_q <= bit_cnt_q + 6'h01;
            end
            else if (link_fall && bit_cnt_q == octal_entry_pkg::INDEX_BITS)
            begin
                shift_q      <= {word_now[30:0], 1'b0};
                miso_q       <= word_now[31];
                last_index_q <= index_q;
                bit_cnt_q    <= bit_cnt_q + 6'h01;
            end
            else if (link_fall && bit_cnt_q > octal_entry_pkg::INDEX_BITS)
            begin
                if (bit_cnt_q == octal_entry_pkg::FRAME_BITS)
                begin
                    // Next word streams on without a new index
                    shift_q      <= {word_next[30:0], 1'b0};
                    miso_q       <= word_next[31];
                    index_q      <= index_q + 8'h01;
                    last_index_q <= index_q + 8'h01;
                    bit_cnt_q    <= octal_entry_pkg::INDEX_BITS + 6'h01;
                end
                else
                begin
                    miso_q    <= shift_q[31];
                    shift_q   <= {shift_q[30:0], 1'b0};
                    bit_cnt_q <= bit_cnt_q + 6'h01;
                end
            end
        end
    end

    assign o_link_miso = miso_q;

endmodule : octal_ddr_entry_sequence_parser

// [sim/octal_ddr_entry_sequence_parser_properties.sv]
`timescale 1ns/1ps
module octal_ddr_entry_sequence_parser_properties
(
    input wire logic        i_sys_clk,
    input wire logic        i_rst_n,
    input wire logic [7:0]  i_avs_address,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0]  i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    input wire logic        i_link_clk,
    input wire logic        i_link_sel_n,
    input wire logic        i_link_mosi,
    input wire logic        o_link_miso
);
    // ------
    // Checks
    // ------
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);
    logic rd_done;
    assign rd_done = i_avs_read && !o_avs_waitrequest;
    property p_wait_answer;
        (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
    endproperty
    a_wait_answer: assert property (p_wait_answer) else $error("bus answer late");
    property p_wait_single;
        !o_avs_waitrequest |=> o_avs_waitrequest;
    endproperty
    a_wait_single: assert property (p_wait_single) else $error("wait low too long");
    property p_wait_idle;
        !(i_avs_read || i_avs_write) |=> o_avs_waitrequest;
    endproperty
    a_wait_idle: assert property (p_wait_idle) else $error("answer without request");
    property p_len_one_based;
        rd_done && i_avs_address == octal_entry_pkg::QUAD_LEN_OFS
            |-> o_avs_readdata[31:8] == 24'h0 && o_avs_readdata[7:0] != 8'h00;
    endproperty
    a_len_one_based: assert property (p_len_one_based) else $error("bad length");
    property p_ptr_aligned;
        rd_done && (i_avs_address == octal_entry_pkg::QUAD_PTR_OFS
            || i_avs_address == octal_entry_pkg::OCTAL_PTR_OFS)
            |-> o_avs_readdata[1:0] == 2'h0 && o_avs_readdata[31:24] == 8'h00;
    endproperty
    a_ptr_aligned: assert property (p_ptr_aligned) else $error("bad pointer");
    property p_seq_count;
        rd_done && i_avs_address == octal_entry_pkg::STATUS_OFS |-> o_avs_readdata[3:1] <= 3'h4;
    endproperty
    a_seq_count: assert property (p_seq_count) else $error("bad sequence count");
    property p_unmapped_zero;
        rd_done && i_avs_address > octal_entry_pkg::STATUS_OFS |-> o_avs_readdata == 32'h0;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped data");
    property p_miso_idle;
        i_link_sel_n [*8] |-> !o_link_miso;
    endproperty
    a_miso_idle: assert property (p_miso_idle) else $error("miso busy when idle");
endmodule : octal_ddr_entry_sequence_parser_properties

// [sim/host_link_model.sv]
`timescale 1ns/1ps
module host_link_model
(
    output logic      o_link_clk,
    output logic      o_link_sel_n,
    output logic      o_link_mosi,
    input  wire logic i_link_miso
);
    // -----------
    // Link master
    // -----------
    initial
    begin
        o_link_clk = 1'b0;
        o_link_sel_n = 1'b1;
        o_link_mosi = 1'b0;
    end
    // Clock stands still outside frames
    task automatic read_word(input logic [7:0] idx, output logic [31:0] word);
        #1.3;
        o_link_sel_n = 1'b0;
        for (int b = 7; b >= 0; b--)
        begin
            o_link_mosi = idx[b];
            #24 o_link_clk = 1'b1;
            #24 o_link_clk = 1'b0;
        end
        for (int b = 31; b >= 0; b--)
        begin
            #24 word[b] = i_link_miso;
            o_link_clk = 1'b1;
            #24 o_link_clk = 1'b0;
        end
        #24 o_link_sel_n = 1'b1;
        o_link_mosi = ~o_link_mosi;
        #48;
    endtask : read_word
    // Header accepted only on full identifier match
    task automatic check_header(input logic [7:0] idx, input logic [7:0] id, output logic ok);
        logic [31:0] w0;
        logic [31:0] w1;
        read_word(idx, w0);
        read_word(idx + 8'h01, w1);
        ok = w0[7:0] === id && w1[31:24] === octal_entry_pkg::IDENT_HIGH;
    endtask : check_header
endmodule : host_link_model

// [sim/octal_ddr_entry_sequence_parser_tb_top.sv]
`timescale 1ns/1ps
module octal_ddr_entry_sequence_parser_tb_top;
    typedef struct packed
    {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic [3:0]  be;
        logic [31:0] rexp;
    } reg_row_t;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        link_clk;
    logic        link_sel_n;
    logic        link_mosi;
    logic        link_miso;
    int          fail_count = 0;
    int          tests_run = 0;
    reg_row_t    rows [12];
    logic [31:0] link_exp [13];
    logic [31:0] got;
    logic        ok;
    always #2.5 sys_clk = ~sys_clk;
    octal_ddr_entry_sequence_parser dut
    (
        .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_avs_address(avs_address),
        .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
        .i_avs_byteenable(avs_byteenable), .o_avs_readdata(avs_readdata),
        .o_avs_waitrequest(avs_waitrequest), .i_link_clk(link_clk),
        .i_link_sel_n(link_sel_n), .i_link_mosi(link_mosi), .o_link_miso(link_miso)
    );
    host_link_model u_host
    (
        .o_link_clk(link_clk), .o_link_sel_n(link_sel_n), .o_link_mosi(link_mosi),
        .i_link_miso(link_miso)
    );
    // -----
    // Tasks
    // -----
    task automatic complete_run();
        $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run
    task automatic check_word(input logic [31:0] g, input logic [31:0] e, input string m);
        tests_run++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask : check_word
    task automatic bus_req(input logic wr, input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] b, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        avs_byteenable <= b;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 50)
        begin
            check_word(32'h0, 32'h1, "bus timeout");
            complete_run();
        end
    endtask : bus_req
    task automatic read_check(input logic [7:0] a, input logic [31:0] e);
        bus_req(1'b0, a, 32'h0, 4'h0, got);
        check_word(got, e, "register read");
    endtask : read_check
    // --------
    // Sequence
    // --------
    initial
    begin
        rows = '{'{8'h00, 32'h03A1B2C3, 4'hF, 32'h03A1B2C3},
                 '{8'h04, 32'hD4E5F607, 4'hF, 32'hD4E5F607},
                 '{8'h08, 32'h07112233, 4'hF, 32'h07112233},
                 '{8'h0C, 32'h44556677, 4'hF, 32'h44556677},
                 '{8'h10, 32'h008899AA, 4'hF, 32'h008899AA},
                 '{8'h14, 32'hBBCCDDEE, 4'hF, 32'hBBCCDDEE},
                 '{8'h18, 32'h05123456, 4'hF, 32'h05123456},
                 '{8'h1C, 32'h789ABCDE, 4'hC, 32'h789A0000},
                 '{8'h20, 32'h00000000, 4'hF, 32'h00000001},
                 '{8'h24, 32'hAB123457, 4'hF, 32'h00123454},
                 '{8'h28, 32'h00000203, 4'hF, 32'h00000200},
                 '{8'h30, 32'hFFFFFFFF, 4'hF, 32'h00000000}};
        link_exp = '{32'h0801000A, 32'hFF000200, 32'h0101000C, 32'hFF123454,
                     32'h03A1B2C3, 32'h00000000, 32'h07112233, 32'h44556677,
                     32'h00000000, 32'h00000000, 32'h05123456, 32'h789A0000,
                     32'h00000000};
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        foreach (rows[i])
        begin
            bus_req(1'b1, rows[i].addr, rows[i].wdata, rows[i].be, got);
            read_check(rows[i].addr, rows[i].rexp);
        end
        $display("register rows done");
        foreach (link_exp[i])
        begin
            u_host.read_word(8'(i), got);
            check_word(got, link_exp[i], "link word");
        end
        $display("link rows done");
        bus_req(1'b1, octal_entry_pkg::STATUS_OFS, 32'hFFFFFFFF, 4'hF, got);
        bus_req(1'b0, octal_entry_pkg::STATUS_OFS, 32'h0, 4'h0, got);
        check_word({29'h0, got[3:1]}, 32'h3, "sequence count");
        check_word(got, 32'h000001A6, "status word");
        u_host.check_header(octal_entry_pkg::IDX_OCTAL_HDR0, 8'h0A, ok);
        check_word({31'h0, ok}, 32'h1, "octal header");
        u_host.check_header(octal_entry_pkg::IDX_QUAD_HDR0, 8'h0A, ok);
        check_word({31'h0, ok}, 32'h0, "quad header taken as octal");
        u_host.check_header(octal_entry_pkg::IDX_QUAD_HDR0, 8'h0C, ok);
        check_word({31'h0, ok}, 32'h1, "quad header");
        $display("status and header tests done");
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        read_check(octal_entry_pkg::QUAD_LEN_OFS, 32'h00000005);
        read_check(octal_entry_pkg::QUAD_PTR_OFS, 32'h00000100);
        read_check(octal_entry_pkg::OCTAL_PTR_OFS, 32'h00000080);
        read_check(8'h00, 32'h00000000);
        u_host.read_word(octal_entry_pkg::IDX_QUAD_HDR0, got);
        check_word(got, 32'h0501000C, "quad header after reset");
        $display("reset tests done");
        complete_run();
    end
endmodule : octal_ddr_entry_sequence_parser_tb_top
bind octal_ddr_entry_sequence_parser octal_ddr_entry_sequence_parser_properties u_props
(
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_link_clk(i_link_clk),
    .i_link_sel_n(i_link_sel_n), .i_link_mosi(i_link_mosi), .o_link_miso(o_link_miso)
);
